/* logic/sdpp_program_port.sv */
`timescale 1ns/10ps
module sdpp_program_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ref_clk_en,
  input wire logic vco_en,
  input wire logic par_load,
  input wire logic [sdpp_pkg::SDPP_FB_W-1:0] par_feedback,
  input wire logic [sdpp_pkg::SDPP_PD_W-1:0] par_post_sel,
  input wire logic ser_clock,
  input wire logic ser_data,
  input wire logic ser_load,
  output logic [sdpp_pkg::SDPP_FB_W-1:0] feedback_ratio,
  output logic [sdpp_pkg::SDPP_PD_W-1:0] post_divider_sel,
  output logic [sdpp_pkg::SDPP_TS_W-1:0] test_select,
  output logic pll_bypass,
  output logic synthesized_clock_out,
  output logic diag_out
);
  import sdpp_pkg::*;

  logic par_load_d, ser_clock_d, ser_load_d;
  logic [SDPP_CFG_W-1:0] serial_config_word;
  logic [SDPP_FB_W-1:0] fb_cnt;
  logic [SDPP_PD_W-1:0] pd_cnt;
  logic [SDPP_TS_W-1:0] ts_reg;
  logic ref_half, synth_q_cnt0, synth_q;
  logic [1:0] synth_q_cnt;

  // post-divider decode, used for normal and bypass paths
  function automatic logic [7:0] sdpp_post_ratio(input logic [1:0] sel);
    case (sdpp_div_t'(sel))
      SDPP_DIV2: sdpp_post_ratio = 8'h02;
      SDPP_DIV4: sdpp_post_ratio = 8'h04;
      SDPP_DIV8: sdpp_post_ratio = 8'h08;
      SDPP_DIV1: sdpp_post_ratio = 8'h01;
      default: sdpp_post_ratio = 8'h02;
    endcase
  endfunction

  // edge detection; pins are synchronous to clk_sys
  wire par_rise = par_load && !par_load_d;
  wire ser_rise = ser_clock && !ser_clock_d;
  wire ser_fall = !ser_load && ser_load_d;
  wire serial_ok = par_load;
  wire [SDPP_FB_W-1:0] ser_fb = serial_config_word[SDPP_FB_LSB +: SDPP_FB_W];
  wire [SDPP_PD_W-1:0] ser_pd = serial_config_word[SDPP_PD_LSB +: SDPP_PD_W];
  wire [SDPP_TS_W-1:0] ser_ts = serial_config_word[SDPP_TS_LSB +: SDPP_TS_W];
  wire shift_msb = serial_config_word[SDPP_CFG_W-1];

  // strobes and shift register; msb first so earliest bit ends at the top
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      par_load_d <= 1'b1; // strobe idles high; avoids a false rise right after reset
      ser_clock_d <= 1'b0;
      ser_load_d <= 1'b0;
      serial_config_word <= 12'h000;
    end else begin
      par_load_d <= par_load;
      ser_clock_d <= ser_clock;
      ser_load_d <= ser_load;
      if (ser_rise && serial_ok)
        serial_config_word <= {serial_config_word[SDPP_CFG_W-2:0], ser_data};
    end
  end

  // held counters; serial strobe wins when both land together
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fb_cnt <= SDPP_FB_RESET;
      pd_cnt <= SDPP_PD_RESET;
      ts_reg <= SDPP_TS_SHIFT_OUT;
    end else if (!par_load) begin
      fb_cnt <= par_feedback;
      pd_cnt <= par_post_sel;
      ts_reg <= SDPP_TS_SHIFT_OUT;
    end else if (ser_fall) begin
      fb_cnt <= ser_fb;
      pd_cnt <= ser_pd;
      ts_reg <= ser_ts;
    end else if (par_rise) begin
      fb_cnt <= par_feedback;
      pd_cnt <= par_post_sel;
    end
  end

  // transparent while strobe low: latch output follows pins directly
  assign feedback_ratio = par_load ? fb_cnt : par_feedback;
  assign post_divider_sel = par_load ? pd_cnt : par_post_sel;
  assign test_select = par_load ? ts_reg : SDPP_TS_SHIFT_OUT;
  assign pll_bypass = (test_select == SDPP_TS_BYPASS);

  // bypass feeds dividers from shift clock edges instead of the vco enable
  wire div_src = pll_bypass ? ser_rise : vco_en;
  wire [7:0] post_ratio_raw = sdpp_post_ratio(post_divider_sel);
  wire [7:0] post_ratio = (pll_bypass && post_ratio_raw == 8'h01) ? 8'h02 : post_ratio_raw;
  wire fb_tick, fb_out, pd_tick, pd_out;

  sdpp_divider u_fb_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(div_src),
    .ratio({1'b0, feedback_ratio}),
    .div_tick(fb_tick),
    .div_out(fb_out)
  );

  sdpp_divider u_pd_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(div_src),
    .ratio(post_ratio),
    .div_tick(pd_tick),
    .div_out(pd_out)
  );

  // reference half and output quarter toggles for diagnostics
  assign synth_q_cnt0 = synth_q_cnt[0]; // toggle every second period gives a quarter rate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ref_half <= 1'b0;
      synth_q_cnt <= 2'h0;
      synth_q <= 1'b0;
    end else begin
      if (ref_clk_en)
        ref_half <= !ref_half;
      if (pd_tick) begin
        synth_q_cnt <= synth_q_cnt + 2'h1;
        if (synth_q_cnt0)
          synth_q <= !synth_q;
      end
    end
  end

  // diagnostic select; registered so the pin is glitch free
  logic next_diag;
  always_comb begin
    case (test_select)
      SDPP_TS_SHIFT_OUT: next_diag = shift_msb;
      SDPP_TS_ONE: next_diag = 1'b1;
      SDPP_TS_REF_HALF: next_diag = ref_half;
      SDPP_TS_FB_CNT: next_diag = fb_out;
      SDPP_TS_SYNTH: next_diag = pd_out;
      SDPP_TS_ZERO: next_diag = 1'b0;
      SDPP_TS_BYPASS: next_diag = fb_out;
      SDPP_TS_SYNTH_Q: next_diag = synth_q;
      default: next_diag = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag_out <= 1'b0;
      synthesized_clock_out <= 1'b0;
    end else begin
      diag_out <= next_diag;
      synthesized_clock_out <= pd_out;
    end
  end
endmodule // sdpp_program_port

/* logic/sdpp_pkg.sv */
package sdpp_pkg;
  localparam int SDPP_CFG_W = 12;
  localparam int SDPP_FB_W = 7;
  localparam int SDPP_PD_W = 2;
  localparam int SDPP_TS_W = 3;
  // field positions in the shift word, last bit shifted sits at bit 0
  localparam int SDPP_FB_LSB = 0;
  localparam int SDPP_PD_LSB = 7;
  localparam int SDPP_TS_LSB = 9;
  localparam logic [2:0] SDPP_TS_SHIFT_OUT = 3'h0;
  localparam logic [2:0] SDPP_TS_ONE = 3'h1;
  localparam logic [2:0] SDPP_TS_REF_HALF = 3'h2;
  localparam logic [2:0] SDPP_TS_FB_CNT = 3'h3;
  localparam logic [2:0] SDPP_TS_SYNTH = 3'h4;
  localparam logic [2:0] SDPP_TS_ZERO = 3'h5;
  localparam logic [2:0] SDPP_TS_BYPASS = 3'h6;
  localparam logic [2:0] SDPP_TS_SYNTH_Q = 3'h7;
  localparam logic [1:0] SDPP_PD_DIV2 = 2'h0;
  localparam logic [1:0] SDPP_PD_DIV4 = 2'h1;
  localparam logic [1:0] SDPP_PD_DIV8 = 2'h2;
  localparam logic [1:0] SDPP_PD_DIV1 = 2'h3;
  localparam logic [6:0] SDPP_FB_RESET = 7'h30;
  localparam logic [1:0] SDPP_PD_RESET = 2'h0;
  localparam int SDPP_CLK_MHZ = 25;
  localparam int SDPP_STROBE_MIN_NS = 50;
  localparam int SDPP_STROBE_MIN_CYC = (SDPP_STROBE_MIN_NS * SDPP_CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    SDPP_DIV2 = 2'b00,
    SDPP_DIV4 = 2'b01,
    SDPP_DIV8 = 2'b10,
    SDPP_DIV1 = 2'b11
  } sdpp_div_t;
endpackage

/* logic/sdpp_divider.sv */
`timescale 1ns/10ps
// counter dividing the enable stream by a ratio; ratio zero or one passes through
module sdpp_divider (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic [7:0] ratio,
  output logic div_tick,
  output logic div_out
);
  logic [7:0] count;
  logic [7:0] half;
  assign half = {1'b0, ratio[7:1]};
  // pulse on wrap; level high for first part of period only, duty not balanced for odd ratios
  assign div_tick = tick && (count + 8'h01 >= ratio);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count <= 8'h00;
      div_out <= 1'b0;
    end else if (tick) begin
      count <= div_tick ? 8'h00 : count + 8'h01;
      div_out <= div_tick ? 1'b1 : ((count + 8'h01) < half);
    end
  end
endmodule // sdpp_divider

/* testbench/sdpp_props.sv */
`timescale 1ns/10ps
module sdpp_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic par_load,
  input wire logic [6:0] par_feedback,
  input wire logic [1:0] par_post_sel,
  input wire logic ser_load,
  input wire logic ser_clock,
  input wire logic synthesized_clock_out,
  input wire logic [6:0] feedback_ratio,
  input wire logic [1:0] post_divider_sel,
  input wire logic [2:0] test_select,
  input wire logic pll_bypass,
  input wire logic diag_out
);
  // one domain, quiet in reset
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_fb_open: assert property (!par_load |-> feedback_ratio == par_feedback)
    else $error("fb open");
  chk_pd_open: assert property (!par_load |-> post_divider_sel == par_post_sel)
    else $error("pd open");
  chk_ts_clear: assert property (!par_load |-> test_select == 3'h0)
    else $error("ts clear");
  chk_bypass_dec: assert property (pll_bypass == (test_select == 3'h6))
    else $error("bypass");
  // pins held stable past the rise must be what stays
  chk_par_cap: assert property (
    $rose(par_load) ##1 (par_load && $stable(par_feedback)) [*2] |->
    feedback_ratio == par_feedback) else $error("par cap");
  // latched select moves only right after a serial strobe fall
  chk_xfer_only: assert property (
    par_load && $past(par_load) && $changed(test_select) |->
    !$past(ser_load) && ($past(ser_load, 2) || $past(ser_load, 3))) else $error("ts moved");
  chk_diag_hi: assert property (
    test_select == 3'h1 && $past(test_select, 2) == 3'h1 |-> diag_out) else $error("diag hi");
  chk_diag_lo: assert property (
    test_select == 3'h5 && $past(test_select, 2) == 3'h5 |-> !diag_out) else $error("diag lo");
  // in bypass the output moves only two cycles after a shift clock rise
  chk_byp_clock: assert property (
    $past(pll_bypass, 2) && $changed(synthesized_clock_out) |->
    $past(ser_clock, 2) && !$past(ser_clock, 3)) else $error("bypass clock");
  // main flows seen
  cov_par: cover property ($rose(par_load));
  cov_ser: cover property (par_load && $fell(ser_load));
  cov_byp: cover property (pll_bypass);
endmodule // sdpp_props

/* testbench/sdpp_host_model.sv */
`timescale 1ns/10ps
// host side: parallel pins and three-wire serial stream
module sdpp_host_model (
  input wire logic clk_sys,
  output logic par_load,
  output logic [6:0] par_feedback,
  output logic [1:0] par_post_sel,
  output logic ser_clock,
  output logic ser_data,
  output logic ser_load
);
  // strobe high from power-up, parallel values first
  initial begin
    par_load = 1'b1;
    {par_feedback, par_post_sel, ser_clock, ser_data, ser_load} = '0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic par(input logic l, input logic [6:0] f, input logic [1:0] p);
    {par_load, par_feedback, par_post_sel} = {l, f, p};
    step(3);
  endtask
  // two cycles per level, wider than the strobe minimum
  task automatic pulses(input int n);
    repeat (n) begin
      ser_clock = 1'b1;
      step(2);
      ser_clock = 1'b0;
      step(2);
    end
  endtask
  // s sets how slowly each bit is presented
  task automatic shift(input logic [11:0] w, input int s);
    for (int i = 11; i >= 0; i--) begin
      ser_data = w[i];
      step(s);
      pulses(1);
    end
    ser_data = ~ser_data; // released line must not look held
  endtask
  task automatic strobe();
    ser_load = 1'b1;
    step(2);
    ser_load = 1'b0;
    step(3);
  endtask
endmodule // sdpp_host_model

/* testbench/test_synth_divider_program_port.sv */
`timescale 1ns/10ps
module test_synth_divider_program_port;
  logic clk_sys, rst, par_load, ser_clock, ser_data, ser_load;
  logic pll_bypass, synthesized_clock_out, diag_out;
  logic [6:0] par_feedback, feedback_ratio;
  logic [1:0] par_post_sel, post_divider_sel;
  logic [2:0] test_select;
  logic ref_clk_en = 1'b0; // analog side out of scope
  logic vco_en = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  int rises = 0;
  int diag_rises = 0;
  wire logic [11:0] act = {test_select, post_divider_sel, feedback_ratio};
  sdpp_host_model host (.*);
  sdpp_program_port uut (.*);
  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge synthesized_clock_out) rises++;
  always @(posedge diag_out) diag_rises++;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // pins flow through while open, then hold once latched
  task automatic t_parallel();
    host.par(1'b0, 7'h55, 2'h1);
    chk(act, 12'h0D5);
    host.par(1'b0, 7'h30, 2'h0);
    host.par(1'b1, 7'h30, 2'h0);
    host.par(1'b1, 7'h0F, 2'h3);
    chk(act, 12'h030);
  endtask
  // every test code; nothing moves before the strobe
  task automatic t_serial();
    logic [11:0] w;
    logic [11:0] p;
    p = 12'h030;
    for (int c = 0; c < 8; c++) begin
      w = {c[2:0], c[1:0], 4'h9, c[2:0]};
      host.shift(w, 1 + c % 2);
      chk(act, p);
      host.strobe();
      chk(act, w);
      chk({11'h0, pll_bypass}, {11'h0, c == 6});
      host.step(2);
      if (c == 1 || c == 5) chk({11'h0, diag_out}, {11'h0, c == 1});
      p = w;
    end
  endtask
  // serial port deaf while the parallel strobe is low; the old word survives
  task automatic t_refuse();
    host.par(1'b0, 7'h30, 2'h0);
    host.shift(12'h4AA, 1);
    host.strobe();
    chk(act, 12'h030);
    host.par(1'b1, 7'h30, 2'h0);
    chk(act, 12'h030);
    host.strobe();
    chk(act, 12'hFCF);
  endtask
  // divide-by-one code halves the shift clock in bypass
  task automatic t_bypass();
    host.shift({3'h6, 2'h3, 7'h02}, 1);
    host.strobe();
    host.pulses(4);
    rises = 0;
    diag_rises = 0;
    host.pulses(16);
    chk(12'(rises), 12'h008);
    chk(12'(diag_rises), 12'h008);
  endtask
  // vco enable every cycle; post select sets the output period
  task automatic t_post_div();
    for (int s = 0; s < 3; s++) begin
      host.par(1'b0, 7'h30, s[1:0]);
      vco_en = 1'b1;
      host.step(16);
      rises = 0;
      host.step(32);
      vco_en = 1'b0;
      chk(12'(rises), 12'(16 >> s));
    end
  endtask
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    host.step(1);
    chk(act, 12'h030);
    t_parallel();
    t_serial();
    t_refuse();
    t_bypass();
    t_post_div();
    report_and_stop();
  end
  // about a thousand cycles are needed; ten times that is a hang
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule // test_synth_divider_program_port
bind sdpp_program_port sdpp_props chk_i (.*);
